// ==== logic/dhf_debug_regs.sv ====
// Debug identity, low-power debug config and halt freeze register bank
`timescale 1ns/1ps
`default_nettype none

module dhf_debug_regs
    import dhf_pkg::*;
#(
    parameter logic [11:0] DEVICE_CODE   = 12'h5a5,  // Arbitrary value
    parameter logic [15:0] REVISION_CODE = 16'h0001  // Arbitrary value
) (
    input  wire logic                       clk_sys,         // 50 MHz system clock
    input  wire logic                       srst,            // System reset, sync
    input  wire logic                       por_rst,         // Power-on reset, async
    input  wire dhf_apb_req_t               apb_req,         // APB request
    output var dhf_apb_rsp_t                apb_rsp,         // APB response
    input  wire logic                       core_halted,     // Core in debug halt
    input  wire logic                       stop_entry,      // Stop mode request pulse
    input  wire logic                       standby_entry,   // Standby request pulse
    input  wire logic                       lp_wakeup,       // Wake event pulse
    output var dhf_lp_out_t                 lp_out,          // Clock/power control
    output logic [DHF_NUM_FREEZE-1:0]       periph_stall     // Per-peripheral freeze
);

    dhf_state_t st_reg;
    dhf_state_t st_next;
    dhf_sel_t   setup_sel;
    dhf_sel_t   wr_sel;
    logic       setup_phase;
    logic       access_fire;
    logic       setup_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and read mux

    function automatic dhf_sel_t reg_select(input logic [31:0] addr);
        case (addr)
            DHF_ADDR_IDENT:  reg_select = DHF_SEL_IDENT;
            DHF_ADDR_CFG:    reg_select = DHF_SEL_CFG;
            DHF_ADDR_FREEZE: reg_select = DHF_SEL_FRZ;
            default:         reg_select = DHF_SEL_NONE;
        endcase
    endfunction : reg_select

    function automatic logic [31:0] ident_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[DHF_DEV_LSB +: DHF_DEV_W] = DEVICE_CODE;
        w[DHF_REV_LSB +: DHF_REV_W] = REVISION_CODE;
        return w;
    endfunction : ident_word

    function automatic logic [31:0] read_mux(input dhf_sel_t sel, input dhf_state_t s);
        case (sel)
            DHF_SEL_IDENT: read_mux = ident_word();
            DHF_SEL_CFG:   read_mux = s.cfg & DHF_CFG_MASK;
            DHF_SEL_FRZ:   read_mux = s.frz & DHF_FREEZE_MASK;
            default:       read_mux = 32'h0000_0000;
        endcase
    endfunction : read_mux

    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign access_fire = apb_req.psel && apb_req.penable;
    assign setup_sel   = reg_select(apb_req.paddr);
    assign wr_sel      = reg_select(apb_req.paddr);
    // Partial writes refused; identity is not writable
    assign setup_bad   = (setup_sel == DHF_SEL_NONE)
                      || (apb_req.pwrite && apb_req.pstrb != DHF_FULL_STRB)
                      || (apb_req.pwrite && setup_sel == DHF_SEL_IDENT);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next                   = st_reg;
        st_next.lp.rc_reselect    = 1'b0;
        st_next.lp.full_reset_req = 1'b0;
        st_next.lp.sys_reset_req  = 1'b0;

        if (setup_phase) begin
            st_next.err   = setup_bad;
            st_next.rdata = (setup_bad || apb_req.pwrite) ? 32'h0000_0000 : read_mux(setup_sel, st_reg);
        end

        // Writes accepted regardless of system reset
        if (access_fire && apb_req.pwrite && !st_reg.err) begin
            case (wr_sel)
                DHF_SEL_CFG: st_next.cfg = apb_req.pwdata & DHF_CFG_MASK;
                DHF_SEL_FRZ: st_next.frz = apb_req.pwdata & DHF_FREEZE_MASK;
                default: ;
            endcase
        end

        case (st_reg.lp_state)
            DHF_LP_RUN: begin
                if (standby_entry) begin
                    st_next.lp_state         = DHF_LP_STDBY;
                    st_next.lp.clocks_run    = st_reg.cfg[DHF_STDBY_KEEP_BIT];
                    st_next.lp.digital_power = st_reg.cfg[DHF_STDBY_KEEP_BIT];
                end else if (stop_entry) begin
                    st_next.lp_state      = DHF_LP_STOP;
                    st_next.lp.clocks_run = st_reg.cfg[DHF_STOP_KEEP_BIT];
                end
            end
            DHF_LP_STOP: begin
                if (lp_wakeup) begin
                    st_next.lp_state       = DHF_LP_RUN;
                    st_next.lp.clocks_run  = 1'b1;
                    st_next.lp.rc_reselect = 1'b1;
                end
            end
            DHF_LP_STDBY: begin
                if (lp_wakeup) begin
                    st_next.lp_state         = DHF_LP_RUN;
                    st_next.lp.clocks_run    = 1'b1;
                    st_next.lp.digital_power = 1'b1;
                    if (st_reg.cfg[DHF_STDBY_KEEP_BIT]) begin
                        st_next.lp.sys_reset_req = 1'b1;
                    end else begin
                        st_next.lp.full_reset_req = 1'b1;
                    end
                end
            end
            default: begin
                st_next.lp_state = DHF_LP_RUN;
            end
        endcase

        // System reset spares the config and freeze words
        if (srst) begin
            // Bus stays live for the debugger during system reset
            if (!setup_phase) begin
                st_next.rdata = 32'h0000_0000;
                st_next.err   = 1'b0;
            end
            st_next.lp_state         = DHF_LP_RUN;
            st_next.lp.clocks_run    = 1'b1;
            st_next.lp.digital_power = 1'b1;
            st_next.lp.rc_reselect   = 1'b0;
            st_next.lp.full_reset_req = 1'b0;
            st_next.lp.sys_reset_req = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register, fully cleared only by power-on reset

    always_ff @(posedge clk_sys or posedge por_rst) begin
        if (por_rst) begin
            st_reg.cfg               <= DHF_CFG_RESET;
            st_reg.frz               <= DHF_FREEZE_RESET;
            st_reg.rdata             <= 32'h0000_0000;
            st_reg.err               <= 1'b0;
            st_reg.lp_state          <= DHF_LP_RUN;
            st_reg.lp.clocks_run     <= 1'b1;
            st_reg.lp.digital_power  <= 1'b1;
            st_reg.lp.rc_reselect    <= 1'b0;
            st_reg.lp.full_reset_req <= 1'b0;
            st_reg.lp.sys_reset_req  <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_fire && st_reg.err;
    assign apb_rsp.prdata  = st_reg.rdata;
    assign lp_out          = st_reg.lp;

    generate
        for (genvar i = 0; i < DHF_NUM_FREEZE; i++) begin : g_stall
            // Bit order: timer A, B, basic, C, calendar, window wd, indep wd, two-wire
            assign periph_stall[i] = core_halted && st_reg.frz[DHF_FRZ_POS[i]];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic wr_ok;
    assign wr_ok = access_fire && apb_req.pwrite && !st_reg.err;

    property p_ident_read;
        @(posedge clk_sys) disable iff (por_rst)
        setup_phase && !apb_req.pwrite && setup_sel == DHF_SEL_IDENT
        |=> apb_rsp.prdata == {REVISION_CODE, 4'h0, DEVICE_CODE};
    endproperty
    a_ident_read: assert property (p_ident_read) else $error("identity read value wrong");

    property p_ident_rev;
        @(posedge clk_sys) disable iff (por_rst)
        access_fire && !apb_req.pwrite && !st_reg.err && wr_sel == DHF_SEL_IDENT
        |-> apb_rsp.prdata[31:16] == REVISION_CODE && apb_rsp.prdata[15:12] == 4'h0;
    endproperty
    a_ident_rev: assert property (p_ident_rev) else $error("revision field wrong");

    property p_partial_refused;
        @(posedge clk_sys) disable iff (por_rst)
        setup_phase && apb_req.pwrite && apb_req.pstrb != DHF_FULL_STRB
        ##1 access_fire |-> apb_rsp.pslverr ##1 $stable(st_reg.cfg) && $stable(st_reg.frz);
    endproperty
    a_partial_refused: assert property (p_partial_refused) else $error("partial write not refused");

    property p_cfg_survives_srst;
        @(posedge clk_sys) disable iff (por_rst)
        srst && !wr_ok |=> st_reg.cfg == $past(st_reg.cfg);
    endproperty
    a_cfg_survives_srst: assert property (p_cfg_survives_srst) else $error("config lost on srst");

    property p_cfg_write_in_srst;
        @(posedge clk_sys) disable iff (por_rst)
        srst && wr_ok && wr_sel == DHF_SEL_CFG |=> st_reg.cfg == ($past(apb_req.pwdata) & DHF_CFG_MASK);
    endproperty
    a_cfg_write_in_srst: assert property (p_cfg_write_in_srst) else $error("config write lost");

    property p_stop_gate;
        @(posedge clk_sys) disable iff (por_rst || srst)
        st_reg.lp_state == DHF_LP_RUN && !standby_entry && stop_entry && !st_reg.cfg[DHF_STOP_KEEP_BIT]
        |=> !lp_out.clocks_run && st_reg.lp_state == DHF_LP_STOP;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("stop did not gate clocks");

    property p_stop_exit;
        @(posedge clk_sys) disable iff (por_rst || srst)
        st_reg.lp_state == DHF_LP_STOP && lp_wakeup |=> lp_out.clocks_run && lp_out.rc_reselect;
    endproperty
    a_stop_exit: assert property (p_stop_exit) else $error("stop exit did not restore RC clock");

    property p_stop_keep;
        @(posedge clk_sys) disable iff (por_rst || srst)
        st_reg.lp_state == DHF_LP_RUN && !standby_entry && stop_entry && st_reg.cfg[DHF_STOP_KEEP_BIT]
        |=> lp_out.clocks_run && st_reg.lp_state == DHF_LP_STOP;
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop keep clocks failed");

    property p_stdby_exit;
        @(posedge clk_sys) disable iff (por_rst || srst)
        st_reg.lp_state == DHF_LP_STDBY && lp_wakeup
        |=> lp_out.full_reset_req == !$past(st_reg.cfg[DHF_STDBY_KEEP_BIT])
            && lp_out.sys_reset_req == $past(st_reg.cfg[DHF_STDBY_KEEP_BIT]);
    endproperty
    a_stdby_exit: assert property (p_stdby_exit) else $error("standby exit reset wrong");

    property p_stdby_power;
        @(posedge clk_sys) disable iff (por_rst || srst)
        st_reg.lp_state == DHF_LP_STDBY |-> lp_out.digital_power == lp_out.clocks_run;
    endproperty
    a_stdby_power: assert property (p_stdby_power) else $error("standby power/clock mismatch");

    property p_frz_survives_srst;
        @(posedge clk_sys) disable iff (por_rst)
        srst && !wr_ok |=> $stable(st_reg.frz);
    endproperty
    a_frz_survives_srst: assert property (p_frz_survives_srst) else $error("freeze lost on srst");

    property p_stall_needs_halt;
        @(posedge clk_sys) disable iff (por_rst)
        !core_halted |-> periph_stall == '0;
    endproperty
    a_stall_needs_halt: assert property (p_stall_needs_halt) else $error("stall without halt");

    property p_timer_a_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[0]] ##1 core_halted |-> periph_stall[0];
    endproperty
    a_timer_a_stall: assert property (p_timer_a_stall) else $error("timer A not frozen");

    property p_timer_b_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[1]] ##1 core_halted |-> periph_stall[1];
    endproperty
    a_timer_b_stall: assert property (p_timer_b_stall) else $error("timer B not frozen");

    property p_basic_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[2]] ##1 core_halted |-> periph_stall[2];
    endproperty
    a_basic_stall: assert property (p_basic_stall) else $error("basic timer not frozen");

    property p_timer_c_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[3]] ##1 core_halted |-> periph_stall[3];
    endproperty
    a_timer_c_stall: assert property (p_timer_c_stall) else $error("timer C not frozen");

    property p_calendar_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[4]] ##1 core_halted |-> periph_stall[4];
    endproperty
    a_calendar_stall: assert property (p_calendar_stall) else $error("calendar not frozen");

    property p_window_wd_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[5]] ##1 core_halted |-> periph_stall[5];
    endproperty
    a_window_wd_stall: assert property (p_window_wd_stall) else $error("window watchdog not frozen");

    property p_wd_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[12] ##1 core_halted |-> periph_stall[6];
    endproperty
    a_wd_stall: assert property (p_wd_stall) else $error("watchdog not frozen");

    property p_two_wire_stall;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok && wr_sel == DHF_SEL_FRZ && apb_req.pwdata[DHF_FRZ_POS[7]] ##1 core_halted |-> periph_stall[7];
    endproperty
    a_two_wire_stall: assert property (p_two_wire_stall) else $error("two-wire timeout not frozen");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (por_rst)
        wr_ok |=> (st_reg.cfg & ~DHF_CFG_MASK) == 32'h0 && (st_reg.frz & ~DHF_FREEZE_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits stored");

    c_cfg_write_srst: cover property (@(posedge clk_sys) srst && wr_ok && wr_sel == DHF_SEL_CFG);
    c_stop_cycle: cover property (@(posedge clk_sys) st_reg.lp_state == DHF_LP_STOP ##1 lp_out.rc_reselect);
    c_stdby_sysrst: cover property (@(posedge clk_sys) lp_out.sys_reset_req);
    c_halt_stall: cover property (@(posedge clk_sys) periph_stall[7]);

endmodule : dhf_debug_regs

`default_nettype wire

// ==== logic/dhf_pkg.sv ====
// Shared constants and types for the debug halt/freeze register bank
package dhf_pkg;

    localparam logic [31:0] DHF_ADDR_IDENT  = 32'h4001_5800;
    localparam logic [31:0] DHF_ADDR_CFG    = 32'h4001_5804;
    localparam logic [31:0] DHF_ADDR_FREEZE = 32'h4001_5808;

    localparam int DHF_DEV_LSB = 0;
    localparam int DHF_DEV_W   = 12;
    localparam int DHF_REV_LSB = 16;
    localparam int DHF_REV_W   = 16;

    localparam int DHF_STOP_KEEP_BIT  = 1;
    localparam int DHF_STDBY_KEEP_BIT = 2;

    localparam logic [31:0] DHF_CFG_MASK    = 32'h0000_0006;
    localparam logic [31:0] DHF_FREEZE_MASK = 32'h0020_1d13;
    localparam logic [31:0] DHF_CFG_RESET    = 32'h0000_0000;
    localparam logic [31:0] DHF_FREEZE_RESET = 32'h0000_0000;
    localparam logic [3:0]  DHF_FULL_STRB    = 4'hf;

    // Freeze bit positions, in stall output order
    localparam int DHF_NUM_FREEZE = 8;
    localparam int DHF_FRZ_POS [DHF_NUM_FREEZE] = '{0, 1, 4, 8, 10, 11, 12, 21};

    typedef enum logic [1:0] {
        DHF_SEL_NONE  = 2'h0,
        DHF_SEL_IDENT = 2'h1,
        DHF_SEL_CFG   = 2'h2,
        DHF_SEL_FRZ   = 2'h3
    } dhf_sel_t;

    typedef enum logic [1:0] {
        DHF_LP_RUN   = 2'b00,
        DHF_LP_STOP  = 2'b01,
        DHF_LP_STDBY = 2'b11
    } dhf_lp_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } dhf_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dhf_apb_rsp_t;

    typedef struct packed {
        logic clocks_run;
        logic digital_power;
        logic rc_reselect;
        logic full_reset_req;
        logic sys_reset_req;
    } dhf_lp_out_t;

    typedef struct packed {
        logic [31:0]   cfg;
        logic [31:0]   frz;
        logic [31:0]   rdata;
        logic          err;
        dhf_lp_state_t lp_state;
        dhf_lp_out_t   lp;
    } dhf_state_t;

endpackage : dhf_pkg

// ==== test/dhf_apb_host.sv ====
// Debug host model driving the register bank over APB
`timescale 1ns/1ps
`default_nettype none

module dhf_apb_host
    import dhf_pkg::*;
(
    input  wire logic         clk_sys, // System clock
    output var  dhf_apb_req_t apb_req, // Request to device
    input  wire dhf_apb_rsp_t apb_rsp  // Device answer
);

    initial apb_req = '0;

    ////////////////////////////////////////
    // One transfer: setup, access held until pready
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                        input logic [3:0] strb, output logic [31:0] rdata, output logic err);
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data, pstrb: strb};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err   = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : xfer

endmodule : dhf_apb_host

`default_nettype wire

// ==== test/dhf_debug_regs_tb.sv ====
// Self-checking testbench for the debug halt/freeze register bank
`timescale 1ns/1ps
`default_nettype none

module dhf_debug_regs_tb;
    import dhf_pkg::*;

    localparam logic [11:0] DEV = 12'h3c7;   // Arbitrary value
    localparam logic [15:0] REV = 16'h00a2;  // Arbitrary value
    localparam logic [31:0] IDW = {REV, 4'h0, DEV};

    logic                      clk_sys, srst, por_rst, core_halted;
    logic                      stop_entry, standby_entry, lp_wakeup;
    dhf_apb_req_t              apb_req;
    dhf_apb_rsp_t              apb_rsp;
    dhf_lp_out_t               lp_out;
    logic [DHF_NUM_FREEZE-1:0] periph_stall;
    logic [31:0]               rd;
    logic                      er;
    int                        fails = 0, checked = 0, cycles = 0;
    int                        pos [8] = '{0, 1, 4, 8, 10, 11, 12, 21};

    dhf_debug_regs #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) dhf_debug_regs_inst (
        .clk_sys(clk_sys), .srst(srst), .por_rst(por_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .core_halted(core_halted), .stop_entry(stop_entry), .standby_entry(standby_entry),
        .lp_wakeup(lp_wakeup), .lp_out(lp_out), .periph_stall(periph_stall));

    dhf_apb_host dhf_apb_host_inst (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));

    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] exp, input logic exp_err);
        dhf_apb_host_inst.xfer(wr, a, d, s, rd, er);
        if (!wr) chk(rd, exp, "read data");
        chk({31'h0, er}, {31'h0, exp_err}, "error response");
    endtask : acc

    // Enter and leave stop or standby with the relevant keep bit set or not
    task automatic lp_cycle(input logic stdby, input logic keep);
        logic [4:0] want;
        want = {keep, stdby ? keep : 1'b1, 3'b000};
        acc(1'b1, DHF_ADDR_CFG, keep ? (stdby ? 32'h4 : 32'h2) : (stdby ? 32'h2 : 32'h4), 4'hf, 0, 1'b0);
        @(posedge clk_sys);
        if (stdby) standby_entry <= 1'b1;
        else stop_entry <= 1'b1;
        @(posedge clk_sys);
        standby_entry <= 1'b0;
        stop_entry <= 1'b0;
        #1;
        chk({27'h0, lp_out}, {27'h0, want}, "low power outputs");
        @(posedge clk_sys) lp_wakeup <= 1'b1;
        @(posedge clk_sys) lp_wakeup <= 1'b0;
        want = {2'b11, ~stdby, stdby & ~keep, stdby & keep};
        #1;
        chk({27'h0, lp_out}, {27'h0, want}, "wake outputs");
    endtask : lp_cycle

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        srst = 1'b1;
        por_rst = 1'b1;
        core_halted = 1'b0;
        stop_entry = 1'b0;
        standby_entry = 1'b0;
        lp_wakeup = 1'b0;
        repeat (2) @(posedge clk_sys);
        por_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        acc(1'b0, DHF_ADDR_IDENT, 0, 4'hf, IDW, 1'b0);
        acc(1'b0, DHF_ADDR_CFG, 0, 4'hf, 32'h0, 1'b0);
        acc(1'b0, DHF_ADDR_FREEZE, 0, 4'hf, 32'h0, 1'b0);
        acc(1'b1, DHF_ADDR_IDENT, 32'hffff_ffff, 4'hf, 0, 1'b1);
        acc(1'b0, DHF_ADDR_IDENT, 0, 4'hf, IDW, 1'b0);
        acc(1'b1, DHF_ADDR_CFG, 32'hffff_ffff, 4'hf, 0, 1'b0);
        acc(1'b0, DHF_ADDR_CFG, 0, 4'hf, 32'h0000_0006, 1'b0);
        acc(1'b1, DHF_ADDR_CFG, 32'h0, 4'h3, 0, 1'b1);
        acc(1'b0, DHF_ADDR_CFG, 0, 4'hf, 32'h0000_0006, 1'b0);
        acc(1'b1, DHF_ADDR_FREEZE, 32'hffff_ffff, 4'hf, 0, 1'b0);
        acc(1'b0, DHF_ADDR_FREEZE, 0, 4'hf, 32'h0020_1d13, 1'b0);
        acc(1'b0, DHF_ADDR_IDENT + 32'hc, 0, 4'hf, 32'h0, 1'b1);
        // Writes under system reset must stick
        @(posedge clk_sys) srst <= 1'b1;
        acc(1'b1, DHF_ADDR_CFG, 32'h2, 4'hf, 0, 1'b0);
        acc(1'b1, DHF_ADDR_FREEZE, 32'h0000_1000, 4'hf, 0, 1'b0);
        @(posedge clk_sys) srst <= 1'b0;
        acc(1'b0, DHF_ADDR_CFG, 0, 4'hf, 32'h2, 1'b0);
        acc(1'b0, DHF_ADDR_FREEZE, 0, 4'hf, 32'h0000_1000, 1'b0);
        // Freeze word written while the core is halted
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys) core_halted <= 1'b1;
            acc(1'b1, DHF_ADDR_FREEZE, 32'h1 << pos[i], 4'hf, 0, 1'b0);
            #1;
            chk({24'h0, periph_stall}, 1 << i, "halted");
            @(posedge clk_sys) core_halted <= 1'b0;
            #1;
            chk({24'h0, periph_stall}, 32'h0, "stall while running");
        end
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 2; k++) begin
                lp_cycle(s[0], k[0]);
            end
        end
        // Power-on reset in mid-run clears both words
        @(posedge clk_sys) por_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        por_rst <= 1'b0;
        acc(1'b0, DHF_ADDR_CFG, 0, 4'hf, 32'h0, 1'b0);
        acc(1'b0, DHF_ADDR_FREEZE, 0, 4'hf, 32'h0, 1'b0);
        give_verdict();
    end

endmodule : dhf_debug_regs_tb

`default_nettype wire
